/* File: logic/gmts_regs.svh */
// Register offsets, field positions, reset values and timing counts of the gyro sequencer.
`ifndef GMTS_REGS_SVH
`define GMTS_REGS_SVH
`define GMTS_ADDR_CTRL 12'h000
`define GMTS_ADDR_STAT 12'h004
`define GMTS_ADDR_CMD 12'h008
`define GMTS_ADDR_RATE 12'h00c
`define GMTS_CTRL_TRIG_BIT 0
`define GMTS_CTRL_SVC_BIT 1
`define GMTS_CTRL_RESET 32'h00000000
`define GMTS_CMD_RESET 3'h1
`define GMTS_CMD_PART 3'h2
`define GMTS_CMD_SERIAL 3'h3
`define GMTS_CMD_CONFIG 3'h4
`define GMTS_CMD_SVC_INIT 3'h5
`define GMTS_CMD_SVC_NORM 3'h6
`define GMTS_STAT_STARTUP_BIT 6
`define GMTS_CLK_HZ 100000000
`define GMTS_SAMPLE_HZ 2000
`define GMTS_TICK_CYC (`GMTS_CLK_HZ / `GMTS_SAMPLE_HZ)
`define GMTS_SETTLE_TICKS 16'h0001
`define GMTS_STAB_TICKS 16'h0010
`define GMTS_RATE_DIV_RESET 16'h0001
`define GMTS_BAUD_DIV 16'h0009
`define GMTS_FRAME_BITS 4'ha
`define GMTS_SENSOR_BYTES 8'h0c
`define GMTS_SPECIAL_BYTES 8'h10
`endif

/* File: logic/gmts_pkg.sv */
// Types shared by the gyro sequencer modules.
package gmts_pkg;
	typedef enum logic [2:0] {
		GMTS_SETTLE = 3'b000,
		GMTS_SEND_PART = 3'b001,
		GMTS_SEND_SERIAL = 3'b011,
		GMTS_SEND_CONFIG = 3'b010,
		GMTS_NORMAL = 3'b110,
		GMTS_SERVICE = 3'b111
	} gmts_mode_type;
	typedef enum logic [1:0] {
		GMTS_DG_SENSOR = 2'h0,
		GMTS_DG_PART = 2'h1,
		GMTS_DG_SERIAL = 2'h2,
		GMTS_DG_CONFIG = 2'h3
	} gmts_dg_type;
endpackage

/* File: logic/gmts_tx_if.sv */
// Request and completion signals between sequencer and serial transmitter.
`timescale 1ns/100ps
interface gmts_tx_if;
	logic start;
	gmts_pkg::gmts_dg_type kind;
	logic busy;
	logic done;
	modport seq (output start, output kind, input busy, input done);
	modport txr (input start, input kind, output busy, output done);
endinterface

/* File: logic/gmts_pin_sync.sv */
// Three-stage synchroniser with agreement filter for one pin.
`timescale 1ns/100ps
module gmts_pin_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic pinIn,
	output logic level
);
	logic [2:0] stage_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage_reg <= 3'h7;
		end else if (clkEn) begin
			stage_reg <= {stage_reg[1:0], pinIn};
		end
	end

	// The filtered level moves only when stages two and three agree.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level <= 1'b1;
		end else if (clkEn && (stage_reg[1] == stage_reg[2])) begin
			level <= stage_reg[2];
		end
	end
endmodule

/* File: logic/gmts_byte_tx.sv */
// Serial datagram transmitter: 8N1 framing, byte count by datagram kind.
`timescale 1ns/100ps
`include "gmts_regs.svh"
module gmts_byte_tx
	import gmts_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [7:0] statusByte,
	gmts_tx_if.txr req,
	output logic txd
);
	logic [15:0] baud_reg;
	logic [3:0] bit_reg;
	logic [7:0] byte_reg;
	logic [7:0] left_reg;
	logic [9:0] shift_reg;
	logic busy_reg;
	logic done_reg;
	logic baudTick;

	assign baudTick = (baud_reg == 16'h0000);
	assign req.busy = busy_reg;
	assign req.done = done_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			baud_reg <= 16'h0000;
			bit_reg <= 4'h0;
			byte_reg <= 8'h00;
			left_reg <= 8'h00;
			shift_reg <= 10'h3ff;
			txd <= 1'b1;
		end else if (clkEn) begin
			done_reg <= 1'b0;
			if (!busy_reg) begin
				if (req.start) begin
					busy_reg <= 1'b1;
					left_reg <= (req.kind == GMTS_DG_SENSOR) ? `GMTS_SENSOR_BYTES
						: `GMTS_SPECIAL_BYTES;
					byte_reg <= statusByte;
					bit_reg <= 4'h0;
					baud_reg <= 16'h0000;
					// Start bit, eight data bits LSB first, one stop bit.
					shift_reg <= {1'b1, statusByte, 1'b0}; // [RULE_24]
				end
			end else if (baudTick) begin
				baud_reg <= `GMTS_BAUD_DIV;
				txd <= shift_reg[0];
				shift_reg <= {1'b1, shift_reg[9:1]};
				if (bit_reg == `GMTS_FRAME_BITS) begin
					bit_reg <= 4'h0;
					if (left_reg == 8'h01) begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
						txd <= 1'b1;
					end else begin
						left_reg <= left_reg - 8'h01;
						byte_reg <= byte_reg + 8'h01;
						// The start bit goes out now, so only data and stop remain.
						shift_reg <= {2'b11, byte_reg + 8'h01}; // [RULE_24]
						txd <= 1'b0;
						bit_reg <= 4'h1;
					end
				end else begin
					bit_reg <= bit_reg + 4'h1;
				end
			end else begin
				baud_reg <= baud_reg - 16'h0001;
			end
		end
	end
endmodule

/* File: logic/gmts_sequencer.sv */
// Mode, trigger and transmit sequencer of the gyro module with APB registers.
//
// Functional notes
// [RULE_01] Reset input is active low, pulled up.
// [RULE_02] Reset forces initialisation mode.
// [RULE_03] Four events enter initialisation mode.
// [RULE_04] Init settles, then sends three special datagrams.
// [RULE_05] Then Normal; specials requestable there.
// [RULE_06] Init datagrams ignore trigger input.
// [RULE_07] Each trigger falling edge sends one datagram; the code ignores edges that come while a datagram is being sent.
// [RULE_08] Triggered mode keeps sampling at full rate.
// [RULE_09] Trigger input pulled up, idles high.
// [RULE_10] Requested special replaces next triggered datagram.
// [RULE_11] Only latest special request is kept.
// [RULE_12] Strobe falls in step with sample period.
// [RULE_13] Strobe rises after datagram's last bit.
// [RULE_14] Strobe framing not needed when triggered.
// [RULE_15] Normal samples fixed rate, sends at rate.
// [RULE_16] Errors never suppress Normal output.
// [RULE_17] Host checks every status byte.
// [RULE_18] Start-up bit 6 set after init.
// [RULE_19] Output continues during stabilisation.
// [RULE_20] Host ignores data until bit 6 clears.
// [RULE_21] Service to Normal skips stabilisation.
// [RULE_22] Free-running output starts without setup.
// [RULE_23] Status byte flags: 1 means fault.
// [RULE_24] Bytes framed 1 start, 8 data, 1 stop.
// [RULE_25] Stabilisation length is a build constant.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "gmts_regs.svh"
module gmts_sequencer
	import gmts_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic external_reset_low,
	input wire logic transmit_trigger_input,
	input wire logic [4:0] faultFlags,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic validity_strobe,
	output logic txd
);
	// ====================================================================
	// Pin inputs and transmitter
	// ====================================================================
	gmts_tx_if txBus();
	logic resetLevel;
	logic trigLevel;
	logic trig_reg;
	logic trigFall;
	logic txd_w;

	// Synchronisers reset high like the pulled-up pins, so no false edge follows.
	gmts_pin_sync u_rst_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.pinIn(external_reset_low),
		.level(resetLevel)
	); // [RULE_01]
	gmts_pin_sync u_trig_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.pinIn(transmit_trigger_input),
		.level(trigLevel)
	); // [RULE_09]

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trig_reg <= 1'b1;
		end else if (clkEn) begin
			trig_reg <= trigLevel;
		end
	end
	assign trigFall = trig_reg && !trigLevel; // [RULE_07]

	logic [7:0] statusByte;
	gmts_byte_tx u_tx (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.statusByte(statusByte),
		.req(txBus.txr),
		.txd(txd_w)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txd <= 1'b1;
		end else if (clkEn) begin
			txd <= txd_w;
		end
	end

	// ====================================================================
	// Registers
	// ====================================================================
	logic [31:0] ctrl_reg;
	logic [15:0] rateDiv_reg;
	logic cmdValid;
	logic [2:0] cmdCode;
	logic apbWrite;
	logic apbRead;
	logic addrOk;

	assign apbWrite = psel && penable && pwrite;
	assign apbRead = psel && !penable && !pwrite;
	assign addrOk = (paddr == `GMTS_ADDR_CTRL) || (paddr == `GMTS_ADDR_STAT)
		|| (paddr == `GMTS_ADDR_CMD) || (paddr == `GMTS_ADDR_RATE);
	assign cmdValid = clkEn && apbWrite && (paddr == `GMTS_ADDR_CMD);
	assign cmdCode = pwdata[2:0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clkEn) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addrOk;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= `GMTS_CTRL_RESET;
			rateDiv_reg <= `GMTS_RATE_DIV_RESET;
		end else if (clkEn && apbWrite && pready) begin
			if (paddr == `GMTS_ADDR_CTRL) begin
				ctrl_reg <= {30'h00000000, pwdata[1:0]};
			end
			if (paddr == `GMTS_ADDR_RATE && pwdata[15:0] != 16'h0000) begin
				rateDiv_reg <= pwdata[15:0];
			end
		end
	end

	// ====================================================================
	// Mode sequencer
	// ====================================================================
	gmts_mode_type mode_reg;
	logic [15:0] tickCnt_reg;
	logic sampleTick;
	logic [15:0] settle_reg;
	logic [15:0] stab_reg;
	logic startup_reg;
	logic [15:0] rateCnt_reg;
	logic rateTick;
	logic start_reg;
	gmts_dg_type kind_reg;
	gmts_dg_type pend_reg;
	logic pendValid_reg;
	logic trigMode;
	logic cmdThis;

	assign trigMode = ctrl_reg[`GMTS_CTRL_TRIG_BIT];
	assign txBus.start = start_reg;
	assign txBus.kind = kind_reg;
	assign cmdThis = cmdValid && pready;

	// Free-running internal sample tick at the fixed internal rate.
	always_ff @(posedge clk) begin
		if (!rst_n || !resetLevel) begin
			tickCnt_reg <= 16'h0000;
		end else if (clkEn) begin
			if (tickCnt_reg == 16'(`GMTS_TICK_CYC - 1)) begin
				tickCnt_reg <= 16'h0000;
			end else begin
				tickCnt_reg <= tickCnt_reg + 16'h0001;
			end
		end
	end
	assign sampleTick = clkEn && (tickCnt_reg == 16'h0000); // [RULE_08] [RULE_15]

	always_ff @(posedge clk) begin
		if (!rst_n || !resetLevel) begin
			rateCnt_reg <= 16'h0000;
		end else if (sampleTick) begin
			if (rateCnt_reg >= rateDiv_reg - 16'h0001) begin
				rateCnt_reg <= 16'h0000;
			end else begin
				rateCnt_reg <= rateCnt_reg + 16'h0001;
			end
		end
	end
	assign rateTick = sampleTick && (rateCnt_reg == 16'h0000); // [RULE_15]

	always_ff @(posedge clk) begin
		if (!rst_n || !resetLevel) begin
			mode_reg <= GMTS_SETTLE; // [RULE_02] [RULE_03]
			settle_reg <= 16'h0000;
			start_reg <= 1'b0;
			kind_reg <= GMTS_DG_SENSOR;
			startup_reg <= 1'b0;
			stab_reg <= 16'h0000;
		end else if (clkEn) begin
			start_reg <= 1'b0;
			if (startup_reg && sampleTick) begin
				if (stab_reg == `GMTS_STAB_TICKS - 16'h0001) begin
					startup_reg <= 1'b0; // [RULE_18] [RULE_25]
				end else begin
					stab_reg <= stab_reg + 16'h0001;
				end
			end
			unique case (mode_reg)
				GMTS_SETTLE: begin
					if (sampleTick) begin
						settle_reg <= settle_reg + 16'h0001;
					end
					if (settle_reg == `GMTS_SETTLE_TICKS) begin
						// Specials go out regardless of trigger configuration.
						mode_reg <= GMTS_SEND_PART; // [RULE_04] [RULE_06]
						start_reg <= 1'b1;
						kind_reg <= GMTS_DG_PART;
					end
				end
				GMTS_SEND_PART: begin
					if (txBus.done) begin
						mode_reg <= GMTS_SEND_SERIAL; // [RULE_04]
						start_reg <= 1'b1;
						kind_reg <= GMTS_DG_SERIAL;
					end
				end
				GMTS_SEND_SERIAL: begin
					if (txBus.done) begin
						mode_reg <= GMTS_SEND_CONFIG; // [RULE_04]
						start_reg <= 1'b1;
						kind_reg <= GMTS_DG_CONFIG;
					end
				end
				GMTS_SEND_CONFIG: begin
					if (txBus.done) begin
						mode_reg <= GMTS_NORMAL; // [RULE_05]
						startup_reg <= 1'b1; // [RULE_18]
						stab_reg <= 16'h0000;
					end
				end
				GMTS_NORMAL: begin
					if (cmdThis && cmdCode == `GMTS_CMD_RESET) begin
						mode_reg <= GMTS_SETTLE; // [RULE_03]
						settle_reg <= 16'h0000;
						startup_reg <= 1'b0;
					end else if (ctrl_reg[`GMTS_CTRL_SVC_BIT]) begin
						mode_reg <= GMTS_SERVICE;
					end else if (!txBus.busy && !start_reg) begin
						// Status errors never gate output; stabilisation neither.
						if (trigMode ? trigFall : rateTick) begin // [RULE_07] [RULE_16] [RULE_19] [RULE_22]
							start_reg <= 1'b1;
							kind_reg <= (trigMode && pendValid_reg) ? pend_reg
								: GMTS_DG_SENSOR; // [RULE_10]
						end
					end
				end
				GMTS_SERVICE: begin
					if (cmdThis && cmdCode == `GMTS_CMD_SVC_INIT) begin
						mode_reg <= GMTS_SETTLE; // [RULE_03]
						settle_reg <= 16'h0000;
					end else if (cmdThis && cmdCode == `GMTS_CMD_SVC_NORM) begin
						mode_reg <= GMTS_NORMAL; // [RULE_21]
						startup_reg <= 1'b0; // [RULE_21]
					end
				end
			endcase
		end
	end

	// Special requests in Normal mode; the latest one overwrites any earlier.
	always_ff @(posedge clk) begin
		if (!rst_n || !resetLevel) begin
			pendValid_reg <= 1'b0;
			pend_reg <= GMTS_DG_PART;
		end else if (clkEn) begin
			if (mode_reg == GMTS_NORMAL && start_reg && kind_reg != GMTS_DG_SENSOR) begin
				pendValid_reg <= 1'b0;
			end
			if (cmdThis && mode_reg == GMTS_NORMAL && cmdCode >= `GMTS_CMD_PART
				&& cmdCode <= `GMTS_CMD_CONFIG) begin
				pendValid_reg <= 1'b1; // [RULE_05] [RULE_11]
				pend_reg <= gmts_dg_type'(2'(cmdCode - 3'h1));
			end
		end
	end

	assign statusByte = {1'b0, startup_reg, faultFlags[4:3], |faultFlags[2:0], faultFlags[2:0]}; // [RULE_23]

	// Strobe falls on each output sample period, rises when the datagram ends, or whenever the transmitter is idle in trigger mode or outside Normal.
	always_ff @(posedge clk) begin
		if (!rst_n || !resetLevel) begin
			validity_strobe <= 1'b1;
		end else if (clkEn) begin
			if (rateTick) begin
				validity_strobe <= 1'b0; // [RULE_12] [RULE_14]
			end else if (txBus.done || (!txBus.busy && !start_reg
				&& (trigMode || mode_reg != GMTS_NORMAL))) begin
				validity_strobe <= 1'b1; // [RULE_13]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (clkEn && apbRead) begin
			unique case (paddr)
				`GMTS_ADDR_CTRL: prdata <= ctrl_reg;
				`GMTS_ADDR_STAT: prdata <= {21'h000000, mode_reg, statusByte};
				`GMTS_ADDR_RATE: prdata <= {16'h0000, rateDiv_reg};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ====================================================================
	// Assertions
	// ====================================================================
	property p_init_first;
		@(posedge clk) disable iff (!rst_n)
		$rose(resetLevel) |-> mode_reg == GMTS_SETTLE;
	endproperty
	a_init_first: assert property (p_init_first) else $error("not in init after reset"); // [RULE_02]
	property p_part_then_serial;
		@(posedge clk) disable iff (!rst_n || !resetLevel)
		(mode_reg == GMTS_SEND_PART && txBus.done && clkEn) |=> kind_reg == GMTS_DG_SERIAL;
	endproperty
	a_part_then_serial: assert property (p_part_then_serial) else $error("order broken"); // [RULE_04]
	property p_normal_after_cfg;
		@(posedge clk) disable iff (!rst_n || !resetLevel)
		(mode_reg == GMTS_SEND_CONFIG && txBus.done && clkEn)
			|=> mode_reg == GMTS_NORMAL && startup_reg;
	endproperty
	a_normal_after_cfg: assert property (p_normal_after_cfg) else $error("no normal"); // [RULE_18]
	property p_trig_send;
		@(posedge clk) disable iff (!rst_n || !resetLevel)
		(clkEn && mode_reg == GMTS_NORMAL && trigMode && trigFall && !txBus.busy
			&& !start_reg && !cmdThis && !ctrl_reg[1]) |=> start_reg;
	endproperty
	a_trig_send: assert property (p_trig_send) else $error("trigger lost"); // [RULE_07]
	property p_strobe_rise;
		@(posedge clk) disable iff (!rst_n || !resetLevel)
		(clkEn && txBus.done && !rateTick) |=> validity_strobe;
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("strobe stuck"); // [RULE_13]
	property p_strobe_fall;
		@(posedge clk) disable iff (!rst_n || !resetLevel)
		rateTick |=> !validity_strobe;
	endproperty
	a_strobe_fall: assert property (p_strobe_fall) else $error("strobe no fall"); // [RULE_12]
	property p_svc_skip;
		@(posedge clk) disable iff (!rst_n || !resetLevel)
		(mode_reg == GMTS_SERVICE && clkEn && cmdThis && cmdCode == `GMTS_CMD_SVC_NORM)
			|=> !startup_reg;
	endproperty
	a_svc_skip: assert property (p_svc_skip) else $error("startup set from service"); // [RULE_21]
	property p_status_bit6;
		@(posedge clk) disable iff (!rst_n)
		statusByte[`GMTS_STAT_STARTUP_BIT] == startup_reg;
	endproperty
	a_status_bit6: assert property (p_status_bit6) else $error("bit 6 wrong"); // [RULE_23]
	c_init_done: cover property (@(posedge clk) mode_reg == GMTS_NORMAL);
	c_trig: cover property (@(posedge clk) trigFall && trigMode);
	c_special: cover property (@(posedge clk) start_reg && kind_reg != GMTS_DG_SENSOR
		&& mode_reg == GMTS_NORMAL);
endmodule

/* File: tb/gmts_host_model.sv */
// Host model: receives serial datagrams from the sequencer and measures their framing.
`timescale 1ns/100ps
module gmts_host_model #(
	parameter int BIT_CYC = 218
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic txd,
	input wire logic validity_strobe,
	output logic [15:0] dgCount,
	output logic [7:0] lastLen,
	output logic frameErr,
	output logic strobeAtStart,
	output logic strobeAtEnd,
	output logic [7:0] firstByte
);
	// ==========================================================
	// Receiver
	// A datagram is closed after three idle bit times on the line.
	initial begin
		logic [7:0] byteCnt;
		logic [7:0] rxByte;
		int gap;
		dgCount = 16'h0000;
		lastLen = 8'h00;
		frameErr = 1'b0;
		strobeAtStart = 1'b0;
		strobeAtEnd = 1'b0;
		firstByte = 8'h00;
		byteCnt = 8'h00;
		rxByte = 8'h00;
		gap = 0;
		forever begin
			@(posedge clk);
			if (rst_n !== 1'b1) begin
				byteCnt = 8'h00;
				gap = 0;
			end else if (txd === 1'b0) begin
				repeat (BIT_CYC / 2) @(posedge clk);
				if (txd !== 1'b0) frameErr = 1'b1;
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CYC) @(posedge clk);
					rxByte[i] = txd;
				end
				repeat (BIT_CYC) @(posedge clk);
				if (txd !== 1'b1) frameErr = 1'b1;
				if (byteCnt == 8'h00) begin
					strobeAtStart = validity_strobe;
					firstByte = rxByte;
				end
				byteCnt = byteCnt + 8'h01;
				gap = 0;
			end else if (byteCnt != 8'h00) begin
				gap++;
				if (gap >= 3 * BIT_CYC) begin
					lastLen = byteCnt;
					strobeAtEnd = validity_strobe;
					dgCount = dgCount + 16'h0001;
					byteCnt = 8'h00;
				end
			end
		end
	end
endmodule

/* File: tb/gmts_sequencer_test.sv */
// Self-checking testbench of the gyro mode and trigger sequencer.
`timescale 1ns/100ps
`include "gmts_regs.svh"
module gmts_sequencer_test
	import gmts_pkg::*;
;
	logic clk, rst_n, clkEn, resetPin, trigPin, psel, penable, pwrite, pready, pslverr;
	logic strobe, txd, frameErr, strobeAtStart, strobeAtEnd;
	logic [4:0] faultFlags;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] dgCount;
	logic [7:0] lastLen, len, firstByte;
	logic err;
	int n_errors = 0;
	int check_count = 0;

	gmts_sequencer uut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .external_reset_low(resetPin),
		.transmit_trigger_input(trigPin), .faultFlags(faultFlags), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .validity_strobe(strobe), .txd(txd));
	gmts_host_model #(.BIT_CYC(int'(`GMTS_BAUD_DIV) + 1)) host (.clk(clk), .rst_n(rst_n),
		.txd(txd), .validity_strobe(strobe),
		.dgCount(dgCount), .lastLen(lastLen), .frameErr(frameErr),
		.strobeAtStart(strobeAtStart), .strobeAtEnd(strobeAtEnd), .firstByte(firstByte));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Expectations, checks and bus tasks
	function automatic logic [7:0] exp_len(input gmts_dg_type kind);
		return (kind == GMTS_DG_SENSOR) ? `GMTS_SENSOR_BYTES : `GMTS_SPECIAL_BYTES;
	endfunction

	// Status byte: integrity, start-up, conditions, overload, any channel, then Z, Y, X.
	function automatic logic [7:0] exp_status(input logic startup, input logic [4:0] f);
		return {1'b0, startup, f[4:3], |f[2:0], f[2:0]};
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic fail_timeout(input string what);
		n_errors++;
		$display("FAIL %s expected response seen timeout", what);
		report_and_stop();
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) fail_timeout("apb ready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_dg();
		int n;
		logic [15:0] c0;
		n = 0;
		c0 = dgCount;
		while (dgCount == c0 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 70000) fail_timeout("datagram");
		len = lastLen;
	endtask

	task automatic wait_init();
		int sum;
		sum = 0;
		while (sum < 48) begin
			wait_dg();
			sum += len;
		end
		check32("init bytes", 3 * exp_len(GMTS_DG_PART), 32'(sum));
	endtask

	task automatic trig_pulse();
		@(posedge clk);
		trigPin <= 1'b0;
		repeat (20) @(posedge clk);
		trigPin <= 1'b1;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [15:0] c0;
		rst_n = 1'b0;
		clkEn = 1'b1;
		resetPin = 1'b1;
		trigPin = 1'b1;
		faultFlags = 5'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		void'($urandom(51027));
		repeat (4) @(posedge clk);
		check32("txd in reset", 32'h1, {31'h0, txd});
		check32("strobe in reset", 32'h1, {31'h0, strobe});
		rst_n <= 1'b1;
		faultFlags <= 5'($urandom) | 5'h10;
		apb(1'b0, `GMTS_ADDR_CTRL, 32'h0);
		check32("ctrl reset", `GMTS_CTRL_RESET, rd);
		apb(1'b0, 12'h010, 32'h0);
		check32("unmapped err", 32'h1, {31'h0, err});
		check32("unmapped data", 32'h0, rd);
		apb(1'b1, `GMTS_ADDR_RATE, 32'h0);
		apb(1'b0, `GMTS_ADDR_RATE, 32'h0);
		check32("rate zero ignored", 32'(`GMTS_RATE_DIV_RESET), rd);
		$display("test registers done");
		wait_init();
		apb(1'b0, `GMTS_ADDR_STAT, 32'h0);
		check32("startup flag", 32'h1, {31'h0, rd[`GMTS_STAT_STARTUP_BIT]});
		$display("test power-on done");
		apb(1'b1, `GMTS_ADDR_CTRL, 32'h1);
		repeat (3) apb(1'b1, `GMTS_ADDR_CMD, 32'(`GMTS_CMD_PART) + 32'($urandom % 3));
		trig_pulse();
		wait_dg();
		check32("special on trigger", 32'(exp_len(GMTS_DG_PART)), 32'(len));
		c0 = dgCount;
		repeat (60000) @(posedge clk);
		check32("no untriggered output", 32'(c0), 32'(dgCount));
		trig_pulse();
		wait_dg();
		check32("sensor on trigger", 32'(exp_len(GMTS_DG_SENSOR)), 32'(len));
		check32("status while starting", 32'(exp_status(1'b1, faultFlags)), 32'(firstByte));
		$display("test trigger done");
		// Service bit is cleared before the exit command, or Normal would fall back at once.
		apb(1'b1, `GMTS_ADDR_CTRL, 32'h2);
		apb(1'b1, `GMTS_ADDR_CTRL, 32'h0);
		apb(1'b1, `GMTS_ADDR_CMD, 32'(`GMTS_CMD_SVC_NORM));
		apb(1'b0, `GMTS_ADDR_STAT, 32'h0);
		check32("no startup flag", 32'h0, {31'h0, rd[`GMTS_STAT_STARTUP_BIT]});
		wait_dg();
		check32("sensor length", 32'(exp_len(GMTS_DG_SENSOR)), 32'(len));
		check32("strobe low in datagram", 32'h0, {31'h0, strobeAtStart});
		check32("strobe high after datagram", 32'h1, {31'h0, strobeAtEnd});
		check32("frame error", 32'h0, {31'h0, frameErr});
		check32("output with faults", 32'(exp_len(GMTS_DG_SENSOR)), 32'(len));
		check32("sensor after service", 32'(exp_len(GMTS_DG_SENSOR)), 32'(len));
		check32("status on link", 32'(exp_status(1'b0, faultFlags)), 32'(firstByte));
		$display("test service done");
		for (int ev = 0; ev < 3; ev++) begin
			if (ev == 0) begin
				apb(1'b1, `GMTS_ADDR_CTRL, 32'h1);
				@(posedge clk);
				resetPin <= 1'b0;
				repeat (20) @(posedge clk);
				resetPin <= 1'b1;
			end else if (ev == 1) begin
				apb(1'b1, `GMTS_ADDR_CTRL, 32'h0);
				apb(1'b1, `GMTS_ADDR_CMD, 32'(`GMTS_CMD_RESET));
			end else begin
				apb(1'b1, `GMTS_ADDR_CTRL, 32'h2);
				apb(1'b1, `GMTS_ADDR_CMD, 32'(`GMTS_CMD_SVC_INIT));
				apb(1'b1, `GMTS_ADDR_CTRL, 32'h0);
			end
			wait_init();
			$display("test init event %0d done", ev);
		end
		report_and_stop();
	end
endmodule
